// [rsc_mem_model.sv]
`timescale 1ns/1ps
module rsc_mem_model (
   // Inputs.
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic busy_i,
   input wire logic [3:0] lat_i,
   input wire logic fail_i,
   // Outputs.
   output logic done_o,
   output logic err_o
);
   logic [3:0] cnt_ff;
   // Answers each command once, lat_i + 1 cycles after it appears.
   always_ff @(posedge clk_i) begin
      if (!resetn_i || done_o || err_o) begin
         cnt_ff <= 4'h0;
         done_o <= 1'b0;
         err_o <= 1'b0;
      end else if (busy_i && cnt_ff == lat_i) begin
         done_o <= !fail_i;
         err_o <= fail_i;
      end else if (busy_i) begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule // rsc_mem_model

// [rsc_pkg.sv]
package rsc_pkg;
   localparam logic [11:0] RSC_ADDR_LO_OFS = 12'h900;
   localparam logic [11:0] RSC_CTL_OFS = 12'h904;
   localparam logic [11:0] RSC_STAT_OFS = 12'h908;
   localparam logic [31:0] RSC_ADDR_LO_RST = 32'h0000_0000;
   localparam logic [31:0] RSC_CTL_RST = 32'h0000_0000;
   localparam int RSC_EN_BIT = 0;
   localparam int RSC_CHN_LSB = 2;
   localparam int RSC_SRC_LSB = 4;
   localparam int RSC_DST_LSB = 8;
   localparam int RSC_PAD_LSB = 16;
   localparam int RSC_WM_LSB = 24;
   localparam int RSC_DISWM_BIT = 29;
   localparam logic [31:0] RSC_CTL_WMASK = 32'h3fff_077d;
   localparam logic [31:0] RSC_NORMOP_DEFAULT = 32'h0000_1000;
   localparam logic [31:0] RSC_ADDR_STEP = 32'h0000_0001;

   typedef enum logic [1:0] {
      RSC_IDLE = 2'b00,
      RSC_NORMAL = 2'b01,
      RSC_READ = 2'b10,
      RSC_WRITE = 2'b11
   } rsc_state_e;

   typedef struct packed {
      logic req;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } rsc_cfg_req_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] chan;
      logic [2:0] rank;
      logic [31:0] addr;
   } rsc_mem_cmd_s;
endpackage

// [rsc_top.sv]
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Low address holds next step; home agent ignored
// [RQ2] Watermark is max(fifo mark, queue credits)
// [RQ3] Disable bit: watermark is fifo mark only
// [RQ4] Normal duration timer expiry opens window
// [RQ5] Watermark exceeded backpressures home agent
// [RQ6] Eight-bit scratch field, no effect
// [RQ7] Writes go to destination rank
// [RQ8] Reads come from source rank
// [RQ9] One engine; channel select picks target
// [RQ10] Independent mode: code picks one channel
// [RQ11] Lock-step: upper bit picks channel pair
// [RQ12] Software sets enable; hardware clears on completion
// [RQ13] Done flag and in-progress flag kept
// [RQ14] Each window copies one address, then advances
module rsc_top #(
   parameter logic [31:0] NORMOP_CYCLES = rsc_pkg::RSC_NORMOP_DEFAULT,
   parameter logic [31:0] LAST_ADDR = 32'h0000_00ff
) (
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // Configuration access.
   input wire rsc_pkg::rsc_cfg_req_s CFG_REQ_I,
   output logic [31:0] CFG_RDATA_O,
   output logic CFG_ACK_O,
   // Home agent side.
   input wire logic HOME_AGENT_HIT_I,
   input wire logic [4:0] WRITE_PENDING_QUEUE_CREDITS_I,
   input wire logic LOCKSTEP_I,
   output logic HOME_AGENT_BACKPRESSURE_O,
   // Memory channel side.
   output rsc_pkg::rsc_mem_cmd_s MEM_CMD_O,
   input wire logic MEM_DONE_I,
   input wire logic MEM_ERR_I
);
   import rsc_pkg::*;

   rsc_state_e state_ff;
   logic [31:0] addr_lo_ff;
   logic [31:0] ctl_ff;
   logic done_ff;
   logic busy_ff;
   logic [5:0] hits_ff;
   logic [31:0] timer_ff;
   logic [31:0] rdata_ff;
   logic ack_ff;
   logic bp_ff;
   rsc_mem_cmd_s cmd_ff;

   logic wr_ctl;
   logic [4:0] wm_mark;
   logic [4:0] eff_wm;
   logic wm_hit;
   logic tmr_hit;
   logic last_step;
   logic finish;
   rsc_mem_cmd_s nxt_cmd;

   function automatic logic [3:0] chan_decode(input logic [1:0] sel, input logic lockstep);
      logic [3:0] res;
      res = 4'h0;
      if (lockstep) begin
         res = sel[1] ? 4'hc : 4'h3; // [RQ11]
      end else begin
         res[sel] = 1'b1; // [RQ10]
      end
      return res;
   endfunction

   assign wr_ctl = CFG_REQ_I.req && CFG_REQ_I.wr && (CFG_REQ_I.addr == RSC_CTL_OFS);
   assign wm_mark = ctl_ff[RSC_WM_LSB +: 5];
   // The larger of the two marks governs unless the queue term is disabled.
   assign eff_wm = (ctl_ff[RSC_DISWM_BIT] || (wm_mark >= WRITE_PENDING_QUEUE_CREDITS_I)) ?
                   wm_mark : WRITE_PENDING_QUEUE_CREDITS_I; // [RQ2] [RQ3]
   assign wm_hit = (hits_ff > {1'b0, eff_wm}); // [RQ2] [RQ3]
   assign tmr_hit = (timer_ff >= NORMOP_CYCLES); // [RQ4]
   assign last_step = (addr_lo_ff >= LAST_ADDR);
   assign finish = (state_ff == RSC_WRITE) && MEM_DONE_I && last_step;

   // Sequencer: normal operation, then a read and a write per window.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         state_ff <= RSC_IDLE;
      end else begin
         case (state_ff)
            RSC_IDLE: begin
               if (ctl_ff[RSC_EN_BIT]) begin
                  state_ff <= RSC_NORMAL;
               end
            end
            RSC_NORMAL: begin
               if (wm_hit || tmr_hit) begin
                  state_ff <= RSC_READ; // [RQ2] [RQ3] [RQ4]
               end
            end
            RSC_READ: begin
               if (MEM_ERR_I) begin
                  state_ff <= RSC_IDLE;
               end else if (MEM_DONE_I) begin
                  state_ff <= RSC_WRITE;
               end
            end
            RSC_WRITE: begin
               if (MEM_ERR_I || finish) begin
                  state_ff <= RSC_IDLE;
               end else if (MEM_DONE_I) begin
                  state_ff <= RSC_NORMAL; // [RQ14]
               end
            end
            default: begin
               state_ff <= RSC_IDLE;
            end
         endcase
      end
   end

   // Hit counter and normal-operation timer restart at each window.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         hits_ff <= 6'h00;
         timer_ff <= 32'h0000_0000;
      end else if (state_ff == RSC_NORMAL) begin
         if (wm_hit || tmr_hit) begin
            hits_ff <= 6'h00;
            timer_ff <= 32'h0000_0000;
         end else begin
            timer_ff <= timer_ff + RSC_ADDR_STEP;
            if (HOME_AGENT_HIT_I && (hits_ff != 6'h3f)) begin
               hits_ff <= hits_ff + 6'h01;
            end
         end
      end else if (state_ff == RSC_IDLE) begin
         hits_ff <= 6'h00;
         timer_ff <= 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         bp_ff <= 1'b0;
      end else begin
         bp_ff <= ((state_ff == RSC_NORMAL) && wm_hit) ||
                  (state_ff == RSC_READ) || (state_ff == RSC_WRITE); // [RQ5]
      end
   end

   // Home agent traffic never touches the address; only steps and software do.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         addr_lo_ff <= RSC_ADDR_LO_RST;
      end else if (CFG_REQ_I.req && CFG_REQ_I.wr && (CFG_REQ_I.addr == RSC_ADDR_LO_OFS)) begin
         addr_lo_ff <= CFG_REQ_I.wdata; // [RQ1]
      end else if ((state_ff == RSC_WRITE) && MEM_DONE_I && !MEM_ERR_I && !last_step) begin
         addr_lo_ff <= addr_lo_ff + RSC_ADDR_STEP; // [RQ1] [RQ14]
      end
   end

   // Control: hardware clears enable at completion or failure.
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         ctl_ff <= RSC_CTL_RST;
      end else begin
         if (wr_ctl) begin
            ctl_ff <= CFG_REQ_I.wdata & RSC_CTL_WMASK; // [RQ6] [RQ12]
         end
         if (finish || (state_ff != RSC_IDLE && state_ff != RSC_NORMAL && MEM_ERR_I)) begin
            ctl_ff[RSC_EN_BIT] <= 1'b0; // [RQ12]
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         if (finish) begin
            done_ff <= 1'b1; // [RQ13]
         end else if (wr_ctl && CFG_REQ_I.wdata[RSC_EN_BIT]) begin
            done_ff <= 1'b0; // [RQ13]
         end
         busy_ff <= (state_ff != RSC_IDLE) && !finish && !MEM_ERR_I; // [RQ13]
      end
   end

   always_comb begin
      nxt_cmd = '0;
      nxt_cmd.addr = addr_lo_ff;
      nxt_cmd.chan = chan_decode(ctl_ff[RSC_CHN_LSB +: 2], LOCKSTEP_I); // [RQ9]
      // A failed step drops the command at once, as the sequencer goes idle.
      if (state_ff == RSC_READ && !MEM_DONE_I && !MEM_ERR_I) begin
         nxt_cmd.rd = 1'b1;
         nxt_cmd.rank = ctl_ff[RSC_SRC_LSB +: 3]; // [RQ8]
      end else if (state_ff == RSC_WRITE && !MEM_DONE_I && !MEM_ERR_I) begin
         nxt_cmd.wr = 1'b1;
         nxt_cmd.rank = ctl_ff[RSC_DST_LSB +: 3]; // [RQ7]
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         cmd_ff <= '0;
      end else begin
         cmd_ff <= nxt_cmd;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         rdata_ff <= 32'h0000_0000;
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= CFG_REQ_I.req;
         rdata_ff <= 32'h0000_0000;
         if (CFG_REQ_I.req && !CFG_REQ_I.wr) begin
            case (CFG_REQ_I.addr)
               RSC_ADDR_LO_OFS: rdata_ff <= addr_lo_ff;
               RSC_CTL_OFS: rdata_ff <= ctl_ff;
               RSC_STAT_OFS: rdata_ff <= {30'h0, done_ff, busy_ff};
               default: rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign CFG_RDATA_O = rdata_ff;
   assign CFG_ACK_O = ack_ff;
   assign HOME_AGENT_BACKPRESSURE_O = bp_ff;
   assign MEM_CMD_O = cmd_ff;
endmodule // rsc_top

// [rsc_top_assertions.sv]
`timescale 1ns/1ps
module rsc_top_checker (
   // Inputs.
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire rsc_pkg::rsc_cfg_req_s CFG_REQ_I,
   input wire logic [31:0] CFG_RDATA_O,
   input wire logic CFG_ACK_O,
   input wire logic LOCKSTEP_I,
   input wire logic HOME_AGENT_BACKPRESSURE_O,
   input wire rsc_pkg::rsc_mem_cmd_s MEM_CMD_O,
   input wire logic MEM_DONE_I,
   input wire logic MEM_ERR_I
);
   import rsc_pkg::*;
   logic [31:0] ctl_ff;
   logic busy;
   assign busy = MEM_CMD_O.rd || MEM_CMD_O.wr;
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I)
         ctl_ff <= 32'h0;
      else if (CFG_REQ_I.req && CFG_REQ_I.wr && CFG_REQ_I.addr == RSC_CTL_OFS)
         ctl_ff <= CFG_REQ_I.wdata;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   ack_after_req_a: assert property (CFG_REQ_I.req |=> CFG_ACK_O)
      else $error("no ack");
   src_rank_a: assert property (MEM_CMD_O.rd |-> MEM_CMD_O.rank == ctl_ff[6:4])
      else $error("bad read rank");
   dst_rank_a: assert property (MEM_CMD_O.wr |-> MEM_CMD_O.rank == ctl_ff[10:8])
      else $error("bad write rank");
   one_engine_a: assert property (!(MEM_CMD_O.rd && MEM_CMD_O.wr))
      else $error("read and write together");
   indep_chan_a: assert property (busy && !LOCKSTEP_I |->
      MEM_CMD_O.chan == 4'h1 << ctl_ff[3:2]) else $error("bad channel");
   pair_chan_a: assert property (busy && LOCKSTEP_I |->
      MEM_CMD_O.chan == (ctl_ff[3] ? 4'hc : 4'h3)) else $error("bad pair");
   cmd_hold_a: assert property (busy && !MEM_DONE_I && !MEM_ERR_I |=> $stable(MEM_CMD_O))
      else $error("command not held");
   read_write_a: assert property (MEM_CMD_O.rd && MEM_DONE_I |=>
      !MEM_CMD_O.rd ##[0:3] MEM_CMD_O.wr) else $error("no write after read");
   window_bp_a: assert property (busy |-> HOME_AGENT_BACKPRESSURE_O)
      else $error("no backpressure");
   err_stop_a: assert property (busy && MEM_ERR_I |=> !busy [*4])
      else $error("engine ran on");
   cover property (MEM_CMD_O.rd && LOCKSTEP_I);
   cover property (MEM_CMD_O.wr && MEM_DONE_I);
   cover property (busy && MEM_ERR_I);
endmodule // rsc_top_checker
bind rsc_top rsc_top_checker u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CFG_REQ_I(CFG_REQ_I),
   .CFG_RDATA_O(CFG_RDATA_O), .CFG_ACK_O(CFG_ACK_O), .LOCKSTEP_I(LOCKSTEP_I),
   .HOME_AGENT_BACKPRESSURE_O(HOME_AGENT_BACKPRESSURE_O), .MEM_CMD_O(MEM_CMD_O),
   .MEM_DONE_I(MEM_DONE_I),
   .MEM_ERR_I(MEM_ERR_I));

// [rsc_top_tb.sv]
`timescale 1ns/1ps
module rsc_top_tb;
   import rsc_pkg::*;
   logic clk = 0;
   logic rstn = 0;
   rsc_cfg_req_s req = '0;
   logic hit = 0;
   logic [4:0] cred = '0;
   logic lock = 0;
   logic [3:0] lat = '0;
   logic fail = 0;
   logic [31:0] rdata, q;
   logic ack, bp, done, err;
   rsc_mem_cmd_s cmd;
   int err_total = 0;
   int checked = 0;
   int n;
   logic [31:0] ct_t [6] = '{32'h05110211, 32'h25000325, 32'h0c000439, 32'h0000054d,
      32'h02000655, 32'h0100076d};
   logic [4:0] cr_t [6] = '{5'd10, 5'd10, 5'd3, 5'd0, 5'd1, 5'd0};
   int lo_t [6] = '{10, 5, 12, 19, 2, 1};
   int hi_t [6] = '{15, 9, 17, 25, 7, 6};
   always #50 clk = ~clk;
   rsc_top #(.NORMOP_CYCLES(32'h14), .LAST_ADDR(32'h3)) DUT (.CLK_I(clk), .RESETN_I(rstn),
      .CFG_REQ_I(req), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .HOME_AGENT_HIT_I(hit),
      .WRITE_PENDING_QUEUE_CREDITS_I(cred), .LOCKSTEP_I(lock),
      .HOME_AGENT_BACKPRESSURE_O(bp), .MEM_CMD_O(cmd), .MEM_DONE_I(done), .MEM_ERR_I(err));
   rsc_mem_model mem (.clk_i(clk), .resetn_i(rstn), .busy_i(cmd.rd | cmd.wr), .lat_i(lat),
      .fail_i(fail), .done_o(done), .err_o(err));
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, g, e);
      end
   endtask
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk) req <= '{1'b1, w, a, d};
      @(posedge clk) req <= '0;
      #1 q = rdata;
      chk({31'h0, ack}, 32'h1);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task poll(input int b, input logic v);
      n = 0;
      q = {32{!v}};
      while (q[b] !== v && n < 40) begin
         acc(1'b0, RSC_STAT_OFS, 32'h0);
         n++;
      end
   endtask
   task tally_and_finish;
      if (err_total == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(RSC_ADDR_LO_OFS, RSC_ADDR_LO_RST);
      rd(RSC_CTL_OFS, RSC_CTL_RST);
      rd(RSC_STAT_OFS, 32'h0);
      acc(1'b1, RSC_CTL_OFS, 32'hc0ff_fffe);
      rd(RSC_CTL_OFS, 32'h00ff_077c);
      rd(12'h90c, 32'h0);
      for (int i = 0; i < 6; i++) begin
         lock <= (i > 3);
         cred <= cr_t[i];
         hit <= (i != 3);
         lat <= 4'(i);
         acc(1'b1, RSC_ADDR_LO_OFS, 32'h3);
         acc(1'b1, RSC_CTL_OFS, ct_t[i]);
         n = 0;
         while (bp !== 1'b1 && n < 40) begin
            #100 n++;
         end
         chk({31'h0, n >= lo_t[i] && n <= hi_t[i]}, 32'h1);
         rd(RSC_ADDR_LO_OFS, 32'h3);
         poll(1, 1'b1);
         chk(q, 32'h2);
         rd(RSC_CTL_OFS, ct_t[i] & 32'hffff_fffe);
      end
      acc(1'b1, RSC_ADDR_LO_OFS, 32'h1);
      acc(1'b1, RSC_CTL_OFS, ct_t[5]);
      poll(1, 1'b1);
      chk(q, 32'h2);
      rd(RSC_ADDR_LO_OFS, 32'h3);
      fail <= 1'b1;
      acc(1'b1, RSC_ADDR_LO_OFS, 32'h3);
      acc(1'b1, RSC_CTL_OFS, ct_t[0]);
      @(posedge clk);
      rd(RSC_STAT_OFS, 32'h1);
      poll(0, 1'b0);
      chk(q, 32'h0);
      rd(RSC_CTL_OFS, ct_t[0] & 32'hffff_fffe);
      tally_and_finish;
   end
endmodule // rsc_top_tb
